// >>> rtl/rx_dma_ready.v
// Receive holding register / FIFO with DMA receiver-ready signalling.
// Assumes all inputs are synchronous to ref_clk; charTick is a one-cycle
// enable pulse per character time from an external divider.
// Assumes software changes the mode inputs only while the store is idle;
// a mode change flushes whatever is stored.
// A character arriving at a full store with no read in the same cycle is dropped and flagged.
// Function
// - Per-character mode: request low while data waits
// - Per-character mode: release request when empty
// - Burst mode asserts on trigger level or timeout
// - Burst mode holds request until FIFO empty
// - Character mode always uses per-character signalling
// - Sixteen-character receive FIFO in FIFO mode
// - Trigger level selectable as 1/4/8/14
// - Mode follows fifoModeEnableBit; reset does not select character mode
`timescale 1ns/1ps
`include "rx_dma_map.vh"
module rx_dma_ready #(
    parameter WIDTH = 8,
    parameter DEPTH = `FIFO_DEPTH,
    parameter AW    = `FIFO_PTR_W
) (
    input  wire             ref_clk,
    input  wire             resetn,
    input  wire             fifoModeEnableBit,
    input  wire             dmaBurstSelectBit,
    input  wire [1:0]       trigSel,
    input  wire             fifoFlush,
    input  wire             charTick,
    input  wire             rxValid,
    input  wire [WIDTH-1:0] rxData,
    input  wire             rdReq,
    output reg  [WIDTH-1:0] rdData_r,
    output reg              rdValid_r,
    output reg  [AW:0]      fillLevel_r,
    output reg              overrun_r,
    output reg              timeout_r,
    output reg              rx_dma_request_n
);
    // Trigger selection decode, used for comparison against the fill
    // Default arm covers the fourteen-character code and unknowns
    function [AW:0] trigLevel;
        input [1:0] sel;
        begin
            case (sel)
                `TRIG_SEL_1:  trigLevel = `TRIG_LVL_1;
                `TRIG_SEL_4:  trigLevel = `TRIG_LVL_4;
                `TRIG_SEL_8:  trigLevel = `TRIG_LVL_8;
                default:      trigLevel = `TRIG_LVL_14;
            endcase
        end
    endfunction

    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_BURST = 2'h1;

    // Capacities per mode; character mode is one holding register
    localparam [AW:0]   CAP_FIFO = DEPTH[AW:0];
    localparam [AW:0]   CAP_CHAR = {{AW{1'b0}}, 1'b1};
    localparam [AW:0]   FILL_ONE = {{AW{1'b0}}, 1'b1};
    localparam [AW-1:0] PTR_ONE  = {{(AW-1){1'b0}}, 1'b1};

    // Store pointers and bookkeeping
    reg  [AW-1:0]    wrPtr_r;
    reg  [AW-1:0]    rdPtr_r;
    reg              fifoModeQ_r;
    reg  [2:0]       idleChars_r;
    reg              rdPend_r;

    // Burst-mode request state
    reg  [1:0]       state_r;
    reg  [1:0]       state_nxt;

    // Combinational decodes of the store
    wire [WIDTH-1:0] memData;
    wire [AW:0]      cap;
    wire             empty;
    wire             full;
    wire             doRd;
    wire             doWr;
    wire             modeChange;
    wire             idleClear;

    // Character mode behaves as a one-deep FIFO
    assign cap        = fifoModeEnableBit ? CAP_FIFO : CAP_CHAR;
    assign empty      = (fillLevel_r == {(AW+1){1'b0}});
    assign full       = (fillLevel_r >= cap);
    assign doRd       = rdReq && !empty;
    // A new character landing in a full store overwrites nothing
    assign doWr       = rxValid && (!full || doRd);
    assign modeChange = (fifoModeEnableBit != fifoModeQ_r);
    // Traffic, an empty store or a mode switch restarts the idle count
    assign idleClear  = !fifoModeEnableBit || empty || doWr || doRd || fifoFlush || modeChange;

    // Registered read port: the read pipeline is two stages deep
    // because the store's data only leaves through a flip-flop
    // Write and read may hit different words in one cycle

    rx_char_mem #(
        .WIDTH (WIDTH),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) uMem (
        .ref_clk (ref_clk),
        .wrEn    (doWr),
        .wrAddr  (wrPtr_r),
        .wrData  (rxData),
        .rdAddr  (rdPtr_r),
        .rdData  (memData)
    );

    // Pointers and fill; switching mode or flushing empties the store
    // A flush beats any write or read in the same cycle, so a character
    // arriving with the flush is lost along with the old contents
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wrPtr_r     <= {AW{1'b0}};
            rdPtr_r     <= {AW{1'b0}};
            fillLevel_r <= {(AW+1){1'b0}};
            fifoModeQ_r <= 1'b0;
            overrun_r   <= 1'b0;
        end else begin
            fifoModeQ_r <= fifoModeEnableBit;
            overrun_r   <= rxValid && full && !doRd;
            if (fifoFlush || modeChange) begin
                wrPtr_r     <= {AW{1'b0}};
                rdPtr_r     <= {AW{1'b0}};
                fillLevel_r <= {(AW+1){1'b0}};
            end else begin
                if (doWr) begin
                    wrPtr_r <= wrPtr_r + PTR_ONE;
                end
                if (doRd) begin
                    rdPtr_r <= rdPtr_r + PTR_ONE;
                end
                if (doWr && !doRd) begin
                    fillLevel_r <= fillLevel_r + FILL_ONE;
                end else if (doRd && !doWr) begin
                    fillLevel_r <= fillLevel_r - FILL_ONE;
                end
            end
        end
    end

    // Read data appears two cycles after an accepted read
    // rdData_r holds its last value between reads, so the host may sample
    // it late; rdValid_r alone marks a fresh character
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rdPend_r  <= 1'b0;
            rdValid_r <= 1'b0;
            rdData_r  <= {WIDTH{1'h0}};
        end else begin
            rdPend_r  <= doRd;
            rdValid_r <= rdPend_r;
            if (rdPend_r) begin
                rdData_r <= memData;
            end
        end
    end

    // Timeout: idle character times counted while data waits in FIFO mode
    // Clear wins over a tick in the same cycle: activity is the very
    // thing whose absence the timeout reports
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            idleChars_r <= 3'h0;
            timeout_r   <= 1'b0;
        end else if (idleClear) begin
            idleChars_r <= 3'h0;
            timeout_r   <= 1'b0;
        end else if (charTick && idleChars_r < `TIMEOUT_CHARS) begin
            idleChars_r <= idleChars_r + 3'h1;
            timeout_r   <= (idleChars_r == `TIMEOUT_CHARS - 1);
        end
    end

    // Burst-mode request state; held until the store drains
    // Leaving burst mode or flushing drops the request at once, so a
    // half-served burst is not resumed later on stale contents
    // Trigger and timeout are both judged on registered values
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (fillLevel_r >= trigLevel(trigSel) || timeout_r) begin
                    state_nxt = ST_BURST;
                end
            end
            ST_BURST: begin
                if (empty) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;                               // Unused code recovers to idle
            end
        endcase
        if (!fifoModeEnableBit || !dmaBurstSelectBit || fifoFlush) begin
            state_nxt = ST_IDLE;
        end
    end

    // Request output; per-character follows occupancy directly
    // Registered output trades one cycle of latency for a clean pin
    // Both modes share one flip-flop, so a mode switch cannot glitch it
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_r          <= ST_IDLE;
            rx_dma_request_n <= 1'b1;
        end else begin
            state_r <= state_nxt;
            if (fifoModeEnableBit && dmaBurstSelectBit) begin
                rx_dma_request_n <= !(state_nxt == ST_BURST);
            end else begin
                rx_dma_request_n <= empty;
            end
        end
    end
endmodule

// >>> rtl/rx_dma_map.vh
// Constants for the receive DMA ready signalling block.
// Included by the design files; definitions only.
`ifndef RX_DMA_MAP_VH
`define RX_DMA_MAP_VH

`define FIFO_DEPTH        16
`define FIFO_PTR_W        4
`define TRIG_SEL_1        2'h0
`define TRIG_SEL_4        2'h1
`define TRIG_SEL_8        2'h2
`define TRIG_SEL_14       2'h3
`define TRIG_LVL_1        5'h01
`define TRIG_LVL_4        5'h04
`define TRIG_LVL_8        5'h08
`define TRIG_LVL_14       5'h0E
`define TIMEOUT_CHARS     4
`define CHAR_TIME_DEFAULT 16'h0200

`endif

// >>> rtl/rx_char_mem.v
// Small character store for the receive FIFO.
// Assumes write and read addresses come from the owning FIFO control.
`timescale 1ns/1ps
module rx_char_mem #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             ref_clk,
    input  wire             wrEn,
    input  wire [AW-1:0]    wrAddr,
    input  wire [WIDTH-1:0] wrData,
    input  wire [AW-1:0]    rdAddr,
    output reg  [WIDTH-1:0] rdData
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];

    // Registered read; data is valid the cycle after the address
    always @(posedge ref_clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end
endmodule

// >>> testbench/rx_dma_ready_monitor.sv
// Assertion checker for the receive DMA request block.
// Assumes mode inputs change only while the store is empty.
`timescale 1ns/1ps
module rx_dma_ready_monitor (
    input wire       ref_clk,
    input wire       resetn,
    input wire       fifoModeEnableBit,
    input wire       dmaBurstSelectBit,
    input wire [1:0] trigSel,
    input wire       fifoFlush,
    input wire       charTick,
    input wire       rxValid,
    input wire       rdReq,
    input wire       rdValid_r,
    input wire [4:0] fillLevel_r,
    input wire       overrun_r,
    input wire       timeout_r,
    input wire       rx_dma_request_n
);
    // Mode decode and trigger threshold
    wire       perChar = !fifoModeEnableBit || !dmaBurstSelectBit;
    wire       burst   = !perChar;
    wire [4:0] trig    = trigSel[1] ? (trigSel[0] ? 5'h0E : 5'h08) : (trigSel[0] ? 5'h04 : 5'h01);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    a_perchar_level: assert property (
        perChar && $past(perChar) |-> rx_dma_request_n == ($past(fillLevel_r) == 5'h00))
        else $error("per-character request level wrong");
    a_burst_trigger: assert property (
        burst && fillLevel_r >= trig && !fifoFlush |=> !rx_dma_request_n)
        else $error("burst request missing at trigger");
    a_burst_quiet: assert property (
        burst && $past(burst) && rx_dma_request_n && fillLevel_r < trig && !timeout_r && !$past(timeout_r)
        |=> rx_dma_request_n)
        else $error("burst request too early");
    a_burst_hold: assert property (
        burst && !rx_dma_request_n && fillLevel_r != 5'h00 && !fifoFlush |=> !rx_dma_request_n)
        else $error("burst request dropped early");
    a_burst_release: assert property (
        burst && fillLevel_r == 5'h00 |=> rx_dma_request_n)
        else $error("burst request held while empty");
    a_depth_limit: assert property (
        fillLevel_r <= (fifoModeEnableBit ? 5'h10 : 5'h01))
        else $error("store deeper than mode allows");
    a_full_drop: assert property (
        fifoModeEnableBit && fillLevel_r == 5'h10 && rxValid && !rdReq && !fifoFlush
        |=> overrun_r && fillLevel_r == 5'h10)
        else $error("full store took a character");
    a_read_answer: assert property (
        rdReq && fillLevel_r != 5'h00 |-> ##2 rdValid_r)
        else $error("read not answered");
    a_timeout_cause: assert property (
        $rose(timeout_r) |-> $past(charTick) && $past(fillLevel_r) != 5'h00)
        else $error("timeout without cause");
    c_burst: cover property (burst && $fell(rx_dma_request_n));
    c_perchar: cover property (perChar && $fell(rx_dma_request_n));
    c_timeout: cover property ($rose(timeout_r));
endmodule
bind rx_dma_ready rx_dma_ready_monitor rx_dma_ready_monitor_i (.ref_clk(ref_clk), .resetn(resetn),
    .fifoModeEnableBit(fifoModeEnableBit), .dmaBurstSelectBit(dmaBurstSelectBit), .trigSel(trigSel),
    .fifoFlush(fifoFlush), .charTick(charTick), .rxValid(rxValid), .rdReq(rdReq), .rdValid_r(rdValid_r),
    .fillLevel_r(fillLevel_r), .overrun_r(overrun_r), .timeout_r(timeout_r), .rx_dma_request_n(rx_dma_request_n));

// >>> testbench/rx_host_model.sv
// Host DMA controller that services the receive request.
// Assumes the request is active low and synchronous to ref_clk.
`timescale 1ns/1ps
module rx_host_model (
    input wire ref_clk,
    input wire resetn,
    input wire enable,
    input wire rxDmaRequestN,
    output reg rdReq
);
    // One read every other cycle; may overshoot by one read when empty
    always @(posedge ref_clk or negedge resetn)
        if (!resetn) rdReq <= 1'b0;
        else rdReq <= enable && !rxDmaRequestN && !rdReq;
endmodule

// >>> testbench/rx_dma_ready_test.sv
// Self-checking bench for the receive DMA request block.
// Assumes the host model drains the store while enabled.
`timescale 1ns/1ps
module rx_dma_ready_test;
    reg refClk = 0, resetN = 0, fifoMode = 0, burst = 0, tick = 0, rxV = 0, tbRd = 0, hostGo = 0;
    reg  [1:0] trig = 2'h0;
    reg  [7:0] rxD  = 8'h40;
    wire [7:0] rdData;
    wire [4:0] fill;
    wire       rdV, tmo, reqN, hostRd, ovr;
    integer    nMismatch = 0, nCompared = 0, i;
    rx_dma_ready rx_dma_ready_i (.ref_clk(refClk), .resetn(resetN), .fifoModeEnableBit(fifoMode),
        .dmaBurstSelectBit(burst), .trigSel(trig), .fifoFlush(1'b0), .charTick(tick), .rxValid(rxV), .rxData(rxD),
        .rdReq(tbRd | hostRd), .rdData_r(rdData), .rdValid_r(rdV), .fillLevel_r(fill), .overrun_r(ovr),
        .timeout_r(tmo), .rx_dma_request_n(reqN));
    rx_host_model rx_host_model_i (.ref_clk(refClk), .resetn(resetN), .enable(hostGo), .rxDmaRequestN(reqN),
        .rdReq(hostRd));
    // Free-running clock
    initial begin
        forever #2.5 refClk = ~refClk;
    end
    task wrapUp; begin
        if (nMismatch == 0 && nCompared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    end endtask
    task chk(input [7:0] got, input [7:0] exp); begin
        nCompared = nCompared + 1;
        if (got !== exp) begin
            nMismatch = nMismatch + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    end endtask
    task tk(input integer n); begin
        repeat (n) begin
            @(posedge refClk);
            #1;
        end
    end endtask
    task push(input integer n); begin
        if (n > 0) begin
            rxV = 1;
            repeat (n) begin
                rxD = rxD + 8'h01;
                tk(1);
            end
            rxV = 0;
        end
    end endtask
    // Bounded drain by the host; every character must come back in order
    task drain(input [7:0] first, input integer n); integer k, got; reg [7:0] expD; begin
        hostGo = 1;
        k = 0;
        got = 0;
        expD = first;
        while ((fill !== 5'h00 || reqN !== 1'b1) && k < 200) begin
            tk(1);
            k = k + 1;
            if (rdV === 1'b1) begin
                chk(rdData, expD);
                expD = expD + 8'h01;
                got = got + 1;
            end
        end
        hostGo = 0;
        if (k == 200) begin
            nMismatch = nMismatch + 1;
            wrapUp;
        end
        tk(2);
        chk(got[7:0], n[7:0]);
    end endtask
    task scChar; begin
        burst = 1;
        rxD = 8'h40;
        push(2);
        chk({7'h0, ovr}, 8'h01);
        tk(1);
        chk({3'h0, fill}, 8'h01);
        chk({7'h0, reqN}, 8'h00);
        tbRd = 1;
        tk(1);
        tbRd = 0;
        tk(1);
        chk({7'h0, rdV}, 8'h01);
        chk(rdData, 8'h41);
        chk({7'h0, reqN}, 8'h01);
    end endtask
    task scPerChar; begin
        burst = 0;
        fifoMode = 1;
        tk(2);
        push(17);
        chk({7'h0, ovr}, 8'h01);
        chk({3'h0, fill}, 8'h10);
        chk({7'h0, reqN}, 8'h00);
        drain(8'h43, 16);
    end endtask
    task scBurst; reg [7:0] first; integer lvl; begin
        burst = 1;
        for (i = 0; i < 4; i = i + 1) begin
            trig = i[1:0];
            lvl = (i == 0) ? 1 : (i == 1) ? 4 : (i == 2) ? 8 : 14;
            first = rxD + 8'h01;
            push(lvl - 1);
            tk(2);
            chk({7'h0, reqN}, 8'h01);
            push(1);
            tk(1);
            chk({7'h0, reqN}, 8'h00);
            drain(first, lvl);
        end
        first = rxD + 8'h01;
        push(1);
        repeat (3) begin
            tick = 1;
            tk(1);
            tick = 0;
            tk(3);
        end
        chk({7'h0, tmo}, 8'h00);
        chk({7'h0, reqN}, 8'h01);
        tick = 1;
        tk(1);
        tick = 0;
        tk(2);
        chk({7'h0, tmo}, 8'h01);
        chk({7'h0, reqN}, 8'h00);
        drain(first, 1);
    end endtask
    // Main sequence
    initial begin
        repeat (6) @(posedge refClk);
        #1 resetN = 1;
        chk({7'h0, reqN}, 8'h01);
        scChar;
        scPerChar;
        scBurst;
        wrapUp;
    end
endmodule
